// ===== design/ssem_pkg.sv
package ssem_pkg;

    localparam logic [7:0] LS_INPUT_MASK_ADDR  = 8'hE7;
    localparam logic [7:0] LS_FAN_MASK_ADDR    = 8'hE8;
    localparam logic [7:0] LS_ANALOG_MASK_ADDR = 8'hE9;
    localparam logic [7:0] DS_INPUT_MASK_ADDR  = 8'hEA;
    localparam logic [7:0] DS_ANALOG_MASK_ADDR = 8'hEB;
    localparam logic [7:0] INPUT_ERR_MASK_ADDR = 8'hEC;

    localparam logic [7:0] LS_INPUT_MASK_RST  = 8'hFF;
    localparam logic [3:0] LS_FAN_MASK_RST    = 4'hF;
    localparam logic [3:0] LS_ANALOG_MASK_RST = 4'h7;
    localparam logic [7:0] DS_INPUT_MASK_RST  = 8'hFF;
    localparam logic [3:0] DS_ANALOG_MASK_RST = 4'h7;
    localparam logic [7:0] INPUT_ERR_MASK_RST = 8'hFF;

    localparam int THERMAL_BIT = 3;
    localparam int FAN_BITS    = 4;
    localparam int ANALOG_BITS = 4;

    typedef enum logic [1:0] {
        SSEM_S0  = 2'h0,
        SSEM_S1  = 2'h1,
        SSEM_S3  = 2'h2,
        SSEM_S45 = 2'h3
    } ssem_sleep_t;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssem_reg_req_t;

    typedef struct packed {
        logic [7:0] input_err;
        logic [3:0] fan_err;
        logic [2:0] analog_err;
        logic       thermal_err;
    } ssem_events_t;

endpackage

// ===== design/ssem_mask_reg.sv
`timescale 1ns/1ps
`default_nettype none
module ssem_mask_reg #(
    parameter int         WIDTH = 8,
    parameter logic [7:0] ADDR  = 8'h00,
    parameter logic [7:0] RST   = 8'h00
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             wr_en_in,
    input  wire logic [7:0]       addr_in,
    input  wire logic [7:0]       wdata_in,
    output logic      [WIDTH-1:0] value_out
);
    logic [WIDTH-1:0] value_d;

    always_comb begin
        value_d = value_out;
        if (wr_en_in && addr_in == ADDR) begin
            value_d = wdata_in[WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            value_out <= RST[WIDTH-1:0];
        end else begin
            value_out <= value_d;
        end
    end
endmodule
`default_nettype wire

// ===== design/ssem_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - light-sleep input mask, 8 bits read/write, bit n hides input n errors in S3, resets to FFh.
// - light-sleep fan mask, bits 0..3 hide fan inputs 1..4 errors in S3, upper bits read 0, resets 0Fh.
// - light-sleep analog mask bits 0..2 hide analog inputs 12..14 errors in S3, reset set.
// - light-sleep analog mask bit 3 hides zone 1 and 2 thermal and diode errors in S3, reset clear.
// - deep-sleep input mask, 8 bits read/write, bit n hides input n errors in S4/5, resets to FFh.
// - deep-sleep analog mask bits 0..2 hide analog inputs 12..14 errors in S4/5, reset set.
// - deep-sleep analog mask bit 3 hides zone thermal and diode errors in S4/5, upper bits read 0.
// - input error mask, 8 bits read/write, hides input n error events in every state, resets FFh.
// - input error mask gates only both input error status sets; the level register stays live.
module ssem_top (
    input  wire logic       CORE_CLK_IN,
    input  wire logic       RST_B_IN,
    input  wire logic       REG_WR_EN_IN,
    input  wire logic [7:0] REG_ADDR_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    input  wire logic [1:0] SLEEP_STATE_IN,
    input  wire logic [7:0] INPUT_ERR_EVT_IN,
    input  wire logic [3:0] FAN_ERR_EVT_IN,
    input  wire logic [2:0] ANALOG_ERR_EVT_IN,
    input  wire logic       THERMAL_ERR_EVT_IN,
    input  wire logic [7:0] GENERAL_INPUT_IN,
    output logic      [7:0] REG_RDATA_OUT,
    output logic      [7:0] INPUT_ERR_B_OUT,
    output logic      [7:0] INPUT_ERR_H_OUT,
    output logic      [7:0] INPUT_LEVEL_OUT,
    output logic      [3:0] FAN_ERR_OUT,
    output logic      [2:0] ANALOG_ERR_OUT,
    output logic            THERMAL_ERR_OUT
);
    ssem_pkg::ssem_reg_req_t req;
    ssem_pkg::ssem_events_t  evt;
    ssem_pkg::ssem_sleep_t   sleep;
    ssem_pkg::ssem_events_t  awake_mask;
    ssem_pkg::ssem_events_t  light_mask;
    ssem_pkg::ssem_events_t  deep_mask;
    ssem_pkg::ssem_events_t  sel_mask;
    ssem_pkg::ssem_events_t  gated;
    logic [7:0]              ls_input_mask;
    logic [3:0]              ls_fan_mask;
    logic [3:0]              ls_analog_mask;
    logic [7:0]              ds_input_mask;
    logic [3:0]              ds_analog_mask;
    logic [7:0]              input_err_mask;
    logic [7:0]              lvl_meta_q;
    logic [7:0]              lvl_sync_q;
    logic [7:0]              lvl_meta_d;
    logic [7:0]              lvl_sync_d;
    logic [7:0]              lvl_d;
    logic [7:0]              rdata_d;
    logic [7:0]              err_b_d;
    logic [7:0]              err_h_d;
    logic [3:0]              fan_d;
    logic [2:0]              analog_d;
    logic                    thermal_d;

    assign req.wr_en = REG_WR_EN_IN;
    assign req.addr  = REG_ADDR_IN;
    assign req.wdata = REG_WDATA_IN;
    assign evt.input_err   = INPUT_ERR_EVT_IN;
    assign evt.fan_err     = FAN_ERR_EVT_IN;
    assign evt.analog_err  = ANALOG_ERR_EVT_IN;
    assign evt.thermal_err = THERMAL_ERR_EVT_IN;
    assign sleep = ssem_pkg::ssem_sleep_t'(SLEEP_STATE_IN);

    ssem_mask_reg #(
        .WIDTH (8),
        .ADDR  (ssem_pkg::LS_INPUT_MASK_ADDR),
        .RST   (ssem_pkg::LS_INPUT_MASK_RST)
    ) u_ls_input (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .wr_en_in  (req.wr_en),
        .addr_in   (req.addr),
        .wdata_in  (req.wdata),
        .value_out (ls_input_mask)
    );

    ssem_mask_reg #(
        .WIDTH (ssem_pkg::FAN_BITS),
        .ADDR  (ssem_pkg::LS_FAN_MASK_ADDR),
        .RST   ({4'h0, ssem_pkg::LS_FAN_MASK_RST})
    ) u_ls_fan (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .wr_en_in  (req.wr_en),
        .addr_in   (req.addr),
        .wdata_in  (req.wdata),
        .value_out (ls_fan_mask)
    );

    // bit 3 is the thermal mask, clear after reset
    ssem_mask_reg #(
        .WIDTH (ssem_pkg::ANALOG_BITS),
        .ADDR  (ssem_pkg::LS_ANALOG_MASK_ADDR),
        .RST   ({4'h0, ssem_pkg::LS_ANALOG_MASK_RST})
    ) u_ls_analog (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .wr_en_in  (req.wr_en),
        .addr_in   (req.addr),
        .wdata_in  (req.wdata),
        .value_out (ls_analog_mask)
    );

    ssem_mask_reg #(
        .WIDTH (8),
        .ADDR  (ssem_pkg::DS_INPUT_MASK_ADDR),
        .RST   (ssem_pkg::DS_INPUT_MASK_RST)
    ) u_ds_input (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .wr_en_in  (req.wr_en),
        .addr_in   (req.addr),
        .wdata_in  (req.wdata),
        .value_out (ds_input_mask)
    );

    ssem_mask_reg #(
        .WIDTH (ssem_pkg::ANALOG_BITS),
        .ADDR  (ssem_pkg::DS_ANALOG_MASK_ADDR),
        .RST   ({4'h0, ssem_pkg::DS_ANALOG_MASK_RST})
    ) u_ds_analog (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .wr_en_in  (req.wr_en),
        .addr_in   (req.addr),
        .wdata_in  (req.wdata),
        .value_out (ds_analog_mask)
    );

    ssem_mask_reg #(
        .WIDTH (8),
        .ADDR  (ssem_pkg::INPUT_ERR_MASK_ADDR),
        .RST   (ssem_pkg::INPUT_ERR_MASK_RST)
    ) u_input_err (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .wr_en_in  (req.wr_en),
        .addr_in   (req.addr),
        .wdata_in  (req.wdata),
        .value_out (input_err_mask)
    );

    // s0 and s1: general input mask only; the s1 set lives elsewhere
    always_comb begin
        awake_mask.input_err   = input_err_mask;
        awake_mask.fan_err     = 4'h0;
        awake_mask.analog_err  = 3'h0;
        awake_mask.thermal_err = 1'b0;
    end

    always_comb begin
        light_mask.input_err   = input_err_mask | ls_input_mask;
        light_mask.fan_err     = ls_fan_mask;
        light_mask.analog_err  = ls_analog_mask[2:0];
        light_mask.thermal_err = ls_analog_mask[ssem_pkg::THERMAL_BIT];
    end

    // no deep-sleep fan mask, so fan events pass in s4/5
    always_comb begin
        deep_mask.input_err   = input_err_mask | ds_input_mask;
        deep_mask.fan_err     = 4'h0;
        deep_mask.analog_err  = ds_analog_mask[2:0];
        deep_mask.thermal_err = ds_analog_mask[ssem_pkg::THERMAL_BIT];
    end

    // every code is a legal state, so no default
    always_comb begin
        sel_mask = awake_mask;
        unique case (sleep)
            ssem_pkg::SSEM_S0: begin
                sel_mask = awake_mask;
            end
            ssem_pkg::SSEM_S1: begin
                sel_mask = awake_mask;
            end
            ssem_pkg::SSEM_S3: begin
                sel_mask = light_mask;
            end
            ssem_pkg::SSEM_S45: begin
                sel_mask = deep_mask;
            end
        endcase
    end

    // a set mask bit forces its event to zero
    always_comb begin
        gated.input_err   = evt.input_err & ~sel_mask.input_err;
        gated.fan_err     = evt.fan_err & ~sel_mask.fan_err;
        gated.analog_err  = evt.analog_err & ~sel_mask.analog_err;
        gated.thermal_err = evt.thermal_err & ~sel_mask.thermal_err;
    end

    // both status sets take the same gated word
    always_comb begin
        err_b_d   = gated.input_err;
        err_h_d   = gated.input_err;
        fan_d     = gated.fan_err;
        analog_d  = gated.analog_err;
        thermal_d = gated.thermal_err;
    end

    // readback: reserved upper bits read as zero
    always_comb begin
        unique case (req.addr)
            ssem_pkg::LS_INPUT_MASK_ADDR: begin
                rdata_d = ls_input_mask;
            end
            ssem_pkg::LS_FAN_MASK_ADDR: begin
                rdata_d = {4'h0, ls_fan_mask};
            end
            ssem_pkg::LS_ANALOG_MASK_ADDR: begin
                rdata_d = {4'h0, ls_analog_mask};
            end
            ssem_pkg::DS_INPUT_MASK_ADDR: begin
                rdata_d = ds_input_mask;
            end
            ssem_pkg::DS_ANALOG_MASK_ADDR: begin
                rdata_d = {4'h0, ds_analog_mask};
            end
            ssem_pkg::INPUT_ERR_MASK_ADDR: begin
                rdata_d = input_err_mask;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // pins are asynchronous: only the second stage reads the first
    always_comb begin
        lvl_meta_d = GENERAL_INPUT_IN;
        lvl_sync_d = lvl_meta_q;
        lvl_d      = lvl_sync_q;
    end

    // level path never sees a mask, so it stays live in every state
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            lvl_meta_q      <= 8'h00;
            lvl_sync_q      <= 8'h00;
            INPUT_LEVEL_OUT <= 8'h00;
        end else begin
            lvl_meta_q      <= lvl_meta_d;
            lvl_sync_q      <= lvl_sync_d;
            INPUT_LEVEL_OUT <= lvl_d;
        end
    end

    // readback lags the address by one edge
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else begin
            REG_RDATA_OUT <= rdata_d;
        end
    end

    // status words are registered so the outputs come from flip-flops
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            INPUT_ERR_B_OUT <= 8'h00;
        end else begin
            INPUT_ERR_B_OUT <= err_b_d;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            INPUT_ERR_H_OUT <= 8'h00;
        end else begin
            INPUT_ERR_H_OUT <= err_h_d;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            FAN_ERR_OUT <= 4'h0;
        end else begin
            FAN_ERR_OUT <= fan_d;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ANALOG_ERR_OUT <= 3'h0;
        end else begin
            ANALOG_ERR_OUT <= analog_d;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            THERMAL_ERR_OUT <= 1'b0;
        end else begin
            THERMAL_ERR_OUT <= thermal_d;
        end
    end
endmodule
`default_nettype wire

// ===== verification/ssem_props.sv
`timescale 1ns/1ps
`default_nettype none
module ssem_props (
    input wire logic       CORE_CLK_IN,
    input wire logic       RST_B_IN,
    input wire logic       REG_WR_EN_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic [1:0] SLEEP_STATE_IN,
    input wire logic [7:0] INPUT_ERR_EVT_IN,
    input wire logic [3:0] FAN_ERR_EVT_IN,
    input wire logic [2:0] ANALOG_ERR_EVT_IN,
    input wire logic       THERMAL_ERR_EVT_IN,
    input wire logic [7:0] GENERAL_INPUT_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic [7:0] INPUT_ERR_B_OUT,
    input wire logic [7:0] INPUT_ERR_H_OUT,
    input wire logic [7:0] INPUT_LEVEL_OUT,
    input wire logic [3:0] FAN_ERR_OUT,
    input wire logic [2:0] ANALOG_ERR_OUT,
    input wire logic       THERMAL_ERR_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    status_pair_a: assert property (INPUT_ERR_B_OUT == INPUT_ERR_H_OUT)
        else $error("status copies differ");
    input_gated_a: assert property ((INPUT_ERR_B_OUT & ~$past(INPUT_ERR_EVT_IN)) == 8'h00)
        else $error("input error without event");
    other_gated_a: assert property (({FAN_ERR_OUT, ANALOG_ERR_OUT, THERMAL_ERR_OUT}
        & ~$past({FAN_ERR_EVT_IN, ANALOG_ERR_EVT_IN, THERMAL_ERR_EVT_IN})) == 8'h00)
        else $error("masked output without event");
    // past reset guard: outputs lag the first edge after release
    awake_pass_a: assert property ($past(RST_B_IN) && $past(SLEEP_STATE_IN) <= 2'h1
        |-> {FAN_ERR_OUT, ANALOG_ERR_OUT, THERMAL_ERR_OUT}
        == $past({FAN_ERR_EVT_IN, ANALOG_ERR_EVT_IN, THERMAL_ERR_EVT_IN}))
        else $error("awake state masked events");
    deep_fan_a: assert property ($past(RST_B_IN) && $past(SLEEP_STATE_IN) == 2'h3
        |-> FAN_ERR_OUT == $past(FAN_ERR_EVT_IN))
        else $error("fan masked in deep sleep");
    level_live_a: assert property ($stable(GENERAL_INPUT_IN)[*4]
        |-> INPUT_LEVEL_OUT == GENERAL_INPUT_IN)
        else $error("level not live");
    write_read_a: assert property (REG_WR_EN_IN
        && REG_ADDR_IN inside {8'hE7, 8'hEA, 8'hEC} ##1 !REG_WR_EN_IN && $stable(REG_ADDR_IN)
        |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
        else $error("written value not read back");
    reserved_zero_a: assert property (REG_ADDR_IN inside {8'hE8, 8'hE9, 8'hEB}
        |=> REG_RDATA_OUT[7:4] == 4'h0)
        else $error("reserved bits not zero");
endmodule
bind ssem_top ssem_props u_props (.*);
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wd = 8'h00;
    logic [1:0]  ss = 2'h0;
    logic [7:0]  gi = 8'h00;
    logic [15:0] ev = 16'hFFFF;
    logic [7:0]  rdata, err_b, err_h, level;
    logic [3:0]  fan;
    logic [2:0]  ana;
    logic        therm;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    logic [7:0]  ra [7] = '{8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED};
    logic [7:0]  rv [7] = '{8'hFF, 8'h0F, 8'h07, 8'hFF, 8'h07, 8'hFF, 8'h00};
    logic [7:0]  fv [7] = '{8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h00};
    logic [7:0]  cv [6] = '{8'h0F, 8'h05, 8'h0A, 8'hF0, 8'h05, 8'h11};
    logic [15:0] ex [4] = '{16'hEEFF, 16'hEEFF, 16'hE0AA, 16'h0EF5};
    ssem_top dut (
        .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .REG_WR_EN_IN(we),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .SLEEP_STATE_IN(ss),
        .INPUT_ERR_EVT_IN(ev[15:8]), .FAN_ERR_EVT_IN(ev[7:4]),
        .ANALOG_ERR_EVT_IN(ev[3:1]), .THERMAL_ERR_EVT_IN(ev[0]),
        .GENERAL_INPUT_IN(gi), .REG_RDATA_OUT(rdata), .INPUT_ERR_B_OUT(err_b),
        .INPUT_ERR_H_OUT(err_h), .INPUT_LEVEL_OUT(level), .FAN_ERR_OUT(fan),
        .ANALOG_ERR_OUT(ana), .THERMAL_ERR_OUT(therm)
    );
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask
    // one edge of latency, one spare edge for the state change
    task automatic evt(input logic [1:0] s, input logic [15:0] e);
        @(posedge clk);
        ss <= s;
        repeat (2) @(posedge clk);
        #1 chk("events", e, {err_b, fan, ana, therm});
        chk("status_h", {8'h00, e[15:8]}, {8'h00, err_h});
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
        evt(2'h2, 16'h0001);
        for (int i = 0; i < 7; i++) begin
            wr(ra[i], 8'hFF);
            rd(ra[i], fv[i]);
        end
        for (int i = 0; i < 6; i++) wr(ra[i], cv[i]);
        for (int s = 0; s < 4; s++) evt(2'(s), ex[s]);
        @(posedge clk);
        gi <= 8'hA5;
        repeat (4) @(posedge clk);
        #1 chk("level", 16'h00A5, {8'h00, level});
        @(posedge clk);
        ev <= 16'h0000;
        evt(2'h0, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
